// ==== include/pgs_pkg.sv ====
// pgs_pkg: register map, field positions and codes of the pin group block.
// assumes a single 100 MHz clock domain and an AXI4-Lite register port.
package pgs_pkg;
	localparam int unsigned PGS_PINS = 32;
	localparam int unsigned PGS_HALF = 16;
	localparam int unsigned PGS_SUB = 8;
	localparam int unsigned PGS_NEV = 4;
	localparam int unsigned PGS_AW = 8;
	localparam int unsigned PGS_FW = 4;
	localparam int unsigned PGS_CW = 4;

	// byte addresses
	localparam logic [7:0] PGS_OFS_SAMPLING = 8'h24;
	localparam logic [7:0] PGS_OFS_MULTICFG = 8'h28;
	localparam logic [7:0] PGS_OFS_EVCTL = 8'h2c;
	localparam logic [7:0] PGS_OFS_OUTVAL = 8'h10;

	localparam logic [31:0] PGS_RST_SAMPLING = 32'h0000_0000;
	localparam logic [31:0] PGS_RST_EVCTL = 32'h0000_0000;
	localparam logic [31:0] PGS_RST_OUTVAL = 32'h0000_0000;
	localparam logic [3:0] PGS_RST_CFG = 4'h0;
	localparam logic [3:0] PGS_RST_FUNC = 4'h0;

	// multi-pin config write fields
	localparam int unsigned PGS_B_HALF = 31;
	localparam int unsigned PGS_B_APPLY_CFG = 30;
	localparam int unsigned PGS_B_APPLY_FUNC = 28;
	localparam int unsigned PGS_B_FUNC_LO = 24;
	localparam int unsigned PGS_B_DRIVE = 22;
	localparam int unsigned PGS_B_PULL = 18;
	localparam int unsigned PGS_B_INBUF = 17;
	localparam int unsigned PGS_B_FSEL = 16;

	// per-pin settings vector layout
	localparam int unsigned PGS_C_FSEL = 0;
	localparam int unsigned PGS_C_INBUF = 1;
	localparam int unsigned PGS_C_PULL = 2;
	localparam int unsigned PGS_C_DRIVE = 3;

	// event control byte layout
	localparam int unsigned PGS_E_ON = 7;
	localparam int unsigned PGS_E_ACT_LO = 5;
	localparam int unsigned PGS_E_PIN_LO = 0;

	localparam logic [3:0] PGS_FUNC_MAX = 4'h8;
	localparam logic [1:0] PGS_AXI_OKAY = 2'b00;
	localparam logic [1:0] PGS_AXI_SLVERR = 2'b10;
	localparam logic [3:0] PGS_STRB_FULL = 4'hf;

	typedef enum logic [1:0] {
		PGS_ACT_COPY,
		PGS_ACT_SET,
		PGS_ACT_CLEAR,
		PGS_ACT_INVERT
	} pgs_act_t;

	typedef enum logic [1:0] {
		PGS_WS_IDLE,
		PGS_WS_RESP
	} pgs_wstate_t;
endpackage

// ==== hdl/pgs_cfg_mem.sv ====
// pgs_cfg_mem: per-pin settings and function codes for 32 pins.
// assumes the caller applies one whole multi-pin update per write pulse.
module pgs_cfg_mem
	import pgs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_we_cfg,
	input wire logic i_we_func,
	input wire logic [PGS_PINS-1:0] i_sel,
	input wire logic [PGS_CW-1:0] i_cfg,
	input wire logic [PGS_FW-1:0] i_func,
	output logic [PGS_PINS*PGS_CW-1:0] o_cfg,
	output logic [PGS_PINS*PGS_FW-1:0] o_func
);
	import pgs_pkg::*;
	logic [PGS_PINS*PGS_CW-1:0] cfg_next;
	logic [PGS_PINS*PGS_FW-1:0] func_next;

	// all selected pins change together in one cycle
	always_comb begin
		cfg_next = o_cfg;
		func_next = o_func;
		for (int p = 0; p < PGS_PINS; p++) begin
			if (i_we_cfg && i_sel[p]) begin
				cfg_next[p*PGS_CW +: PGS_CW] = i_cfg;
			end
			if (i_we_func && i_sel[p]) begin
				func_next[p*PGS_FW +: PGS_FW] = i_func;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_cfg <= {PGS_PINS{PGS_RST_CFG}};
			o_func <= {PGS_PINS{PGS_RST_FUNC}};
		end else begin
			o_cfg <= cfg_next;
			o_func <= func_next;
		end
	end
endmodule

// ==== hdl/pgs_sampler.sv ====
// pgs_sampler: two-stage input synchronizers switched per eight-pin sub-group.
// assumes pin levels may change at any time.
module pgs_sampler
	import pgs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [PGS_PINS-1:0] i_pins,
	input wire logic [PGS_PINS-1:0] i_sub_on,
	output logic [PGS_PINS-1:0] o_level
);
	import pgs_pkg::*;
	logic [PGS_PINS-1:0] s1_reg;
	logic [PGS_PINS-1:0] s1_next;
	logic [PGS_PINS-1:0] s2_next;

	// disabled synchronizers hold their last value
	always_comb begin
		for (int p = 0; p < PGS_PINS; p++) begin
			s1_next[p] = i_sub_on[p] ? i_pins[p] : s1_reg[p];
			s2_next[p] = i_sub_on[p] ? s1_reg[p] : o_level[p];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_reg <= '0;
			o_level <= '0;
		end else begin
			s1_reg <= s1_next;
			o_level <= s2_next;
		end
	end
endmodule

// ==== hdl/pgs_port_group.sv ====
// pgs_port_group: sampling control, multi-pin config write and event actions
// for one 32-pin group, registers on AXI4-Lite.
// assumes events arrive as one-cycle pulses with a level, synchronous to i_clk.
//
// Function
// RL1: sampling bit one enables that pin's input synchronizer, zero disables it only when the other seven bits of its byte are zero too.
// RL2: any sampling bit set in a byte enables all eight synchronizers of that byte.
// RL3: multi-pin config register is write-only and always reads zero.
// RL4: byte and half-word writes to multi-pin config register are ignored.
// RL5: bit 31 selects pins 0-15 or pins 16-31.
// RL6: low 16 bits mask which pins of the half are updated.
// RL7: bit 30 loads drive, pull, input and function-enable settings to selected pins.
// RL8: drive bit 22, pull bit 18, input bit 17, function enable bit 16.
// RL9: bit 28 loads the function code from bits 27:24 into selected pins.
// RL10: event control holds four event inputs, one byte each.
// RL11: enable bits 31, 23, 15, 7 gate each event input.
// RL12: action 0 copies level, 1 sets, 2 clears, 3 inverts the output bit.
// RL13: five-bit target field picks one of 32 pins.
// RL14: function codes 0-8 select functions A-I, 9-15 are reserved.
// RL15: function enable gives pin direction and output to the selected peripheral.
// RL16: one accepted multi-pin write updates all selected pins in one cycle.
// RL17: while write protected, writes to the three registers change nothing.
module pgs_port_group
	import pgs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	// axi4-lite slave
	input wire logic [PGS_AW-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [PGS_AW-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// protection, pins, events, peripherals
	input wire logic i_write_protect_unit,
	input wire logic [PGS_PINS-1:0] i_pins,
	input wire logic [PGS_PINS-1:0] i_dir,
	input wire logic [PGS_NEV-1:0] i_event,
	input wire logic [PGS_NEV-1:0] i_event_level,
	input wire logic [PGS_PINS-1:0] i_periph_dir,
	input wire logic [PGS_PINS-1:0] i_periph_out,
	output logic [PGS_PINS-1:0] o_pin_out,
	output logic [PGS_PINS-1:0] o_pin_oe,
	output logic [PGS_PINS-1:0] o_pin_in,
	output logic [PGS_PINS-1:0] o_sampling_on,
	output logic [PGS_PINS-1:0] o_drive_strength,
	output logic [PGS_PINS-1:0] o_pull_resistor_on,
	output logic [PGS_PINS-1:0] o_input_buffer_on,
	output logic [PGS_PINS-1:0] o_function_select_on,
	output logic [PGS_PINS*PGS_FW-1:0] o_function_code,
	output logic [PGS_PINS-1:0] o_function_reserved
);
	import pgs_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic [PGS_PINS-1:0] sub_group_on(input logic [PGS_PINS-1:0] s);
		logic [PGS_PINS-1:0] r;
		r = '0;
		for (int g = 0; g < PGS_PINS / PGS_SUB; g++) begin
			r[g*PGS_SUB +: PGS_SUB] = {PGS_SUB{|s[g*PGS_SUB +: PGS_SUB]}};
		end
		return r;
	endfunction

	function automatic logic [PGS_PINS-1:0] half_mask(input logic [31:0] d);
		logic [PGS_PINS-1:0] r;
		if (d[PGS_B_HALF]) begin
			r = {d[PGS_HALF-1:0], {PGS_HALF{1'b0}}};
		end else begin
			r = {{PGS_HALF{1'b0}}, d[PGS_HALF-1:0]};
		end
		return r;
	endfunction

	// ==========================================================
	// axi4-lite write channel
	pgs_wstate_t ws_reg, ws_next;
	logic aw_hold_reg, aw_hold_next;
	logic w_hold_reg, w_hold_next;
	logic [PGS_AW-1:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic [1:0] bresp_next;
	logic bvalid_next;
	logic wr_fire;
	logic [PGS_AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;

	always_comb begin
		ws_next = ws_reg;
		aw_hold_next = aw_hold_reg;
		w_hold_next = w_hold_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bresp_next = o_bresp;
		bvalid_next = o_bvalid;
		wr_fire = 1'b0;
		wr_addr = aw_hold_reg ? awaddr_reg : i_awaddr;
		wr_data = w_hold_reg ? wdata_reg : i_wdata;
		wr_strb = w_hold_reg ? wstrb_reg : i_wstrb;
		case (ws_reg)
			PGS_WS_IDLE: begin
				if (o_awready && i_awvalid) begin
					aw_hold_next = 1'b1;
					awaddr_next = i_awaddr;
				end
				if (o_wready && i_wvalid) begin
					w_hold_next = 1'b1;
					wdata_next = i_wdata;
					wstrb_next = i_wstrb;
				end
				// a channel counts only when its ready was up at the edge
				if ((aw_hold_reg || (o_awready && i_awvalid))
					&& (w_hold_reg || (o_wready && i_wvalid))) begin
					wr_fire = 1'b1;
					aw_hold_next = 1'b0;
					w_hold_next = 1'b0;
					bvalid_next = 1'b1;
					bresp_next = wr_ok ? PGS_AXI_OKAY : PGS_AXI_SLVERR;
					ws_next = PGS_WS_RESP;
				end
			end
			PGS_WS_RESP: begin
				if (i_bready) begin
					bvalid_next = 1'b0;
					ws_next = PGS_WS_IDLE;
				end
			end
			default: begin
				ws_next = PGS_WS_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ws_reg <= PGS_WS_IDLE;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			o_bresp <= PGS_AXI_OKAY;
			o_bvalid <= 1'b0;
			o_awready <= 1'b0;
			o_wready <= 1'b0;
		end else begin
			ws_reg <= ws_next;
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			o_bresp <= bresp_next;
			o_bvalid <= bvalid_next;
			o_awready <= (ws_next == PGS_WS_IDLE) && !aw_hold_next;
			o_wready <= (ws_next == PGS_WS_IDLE) && !w_hold_next;
		end
	end

	// ==========================================================
	// register writes
	logic [31:0] sampling_reg, sampling_next;
	logic [31:0] evctl_reg, evctl_next;
	logic [31:0] outval_reg, outval_next;
	logic mc_hit;
	logic mc_cfg_we, mc_func_we;
	logic [PGS_PINS-1:0] mc_sel;
	logic [PGS_CW-1:0] mc_cfg;
	logic [PGS_FW-1:0] mc_func;

	assign wr_ok = (wr_addr == PGS_OFS_SAMPLING) || (wr_addr == PGS_OFS_MULTICFG)
		|| (wr_addr == PGS_OFS_EVCTL) || (wr_addr == PGS_OFS_OUTVAL);
	// only full-width unprotected writes act
	assign mc_hit = wr_fire && (wr_addr == PGS_OFS_MULTICFG) && (wr_strb == PGS_STRB_FULL)
		&& !i_write_protect_unit; // see RL4 see RL17
	assign mc_cfg_we = mc_hit && wr_data[PGS_B_APPLY_CFG]; // see RL7
	assign mc_func_we = mc_hit && wr_data[PGS_B_APPLY_FUNC]; // see RL9
	assign mc_sel = half_mask(wr_data); // see RL5 see RL6
	always_comb begin
		mc_cfg = '0;
		mc_cfg[PGS_C_DRIVE] = wr_data[PGS_B_DRIVE]; // see RL8
		mc_cfg[PGS_C_PULL] = wr_data[PGS_B_PULL];
		mc_cfg[PGS_C_INBUF] = wr_data[PGS_B_INBUF];
		mc_cfg[PGS_C_FSEL] = wr_data[PGS_B_FSEL];
		mc_func = wr_data[PGS_B_FUNC_LO +: PGS_FW];
	end

	always_comb begin
		sampling_next = sampling_reg;
		evctl_next = evctl_reg;
		outval_next = outval_reg;
		if (wr_fire && !i_write_protect_unit) begin // see RL17
			for (int b = 0; b < 4; b++) begin
				if (wr_strb[b]) begin
					if (wr_addr == PGS_OFS_SAMPLING) begin
						sampling_next[b*8 +: 8] = wr_data[b*8 +: 8];
					end
					if (wr_addr == PGS_OFS_EVCTL) begin
						evctl_next[b*8 +: 8] = wr_data[b*8 +: 8];
					end
					if (wr_addr == PGS_OFS_OUTVAL) begin
						outval_next[b*8 +: 8] = wr_data[b*8 +: 8];
					end
				end
			end
		end
		// events applied after software write, so they win
		for (int e = 0; e < PGS_NEV; e++) begin
			logic [7:0] cb;
			logic [4:0] tgt;
			cb = evctl_reg[e*8 +: 8]; // see RL10
			tgt = cb[PGS_E_PIN_LO +: 5]; // see RL13
			if (cb[PGS_E_ON] && i_event[e]) begin // see RL11
				case (pgs_act_t'(cb[PGS_E_ACT_LO +: 2])) // see RL12
					PGS_ACT_COPY: outval_next[tgt] = i_event_level[e];
					PGS_ACT_SET: outval_next[tgt] = 1'b1;
					PGS_ACT_CLEAR: outval_next[tgt] = 1'b0;
					PGS_ACT_INVERT: outval_next[tgt] = ~outval_next[tgt];
					default: outval_next[tgt] = outval_next[tgt];
				endcase
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sampling_reg <= PGS_RST_SAMPLING;
			evctl_reg <= PGS_RST_EVCTL;
			outval_reg <= PGS_RST_OUTVAL;
		end else begin
			sampling_reg <= sampling_next;
			evctl_reg <= evctl_next;
			outval_reg <= outval_next;
		end
	end

	// ==========================================================
	// per-pin storage and samplers
	logic [PGS_PINS*PGS_CW-1:0] cfg_all;
	logic [PGS_PINS*PGS_FW-1:0] func_all;
	logic [PGS_PINS-1:0] sub_on;
	logic [PGS_PINS-1:0] level;

	pgs_cfg_mem u_cfg (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_we_cfg(mc_cfg_we),
		.i_we_func(mc_func_we),
		.i_sel(mc_sel),
		.i_cfg(mc_cfg),
		.i_func(mc_func),
		.o_cfg(cfg_all),
		.o_func(func_all)
	); // see RL16

	assign sub_on = sub_group_on(sampling_reg); // see RL1 see RL2

	pgs_sampler u_samp (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pins(i_pins),
		.i_sub_on(sub_on),
		.o_level(level)
	);

	// ==========================================================
	// pad control and outputs
	logic [PGS_PINS-1:0] fsel, pout, poe, inbuf, rsvd;
	always_comb begin
		for (int p = 0; p < PGS_PINS; p++) begin
			fsel[p] = cfg_all[p*PGS_CW + PGS_C_FSEL];
			inbuf[p] = cfg_all[p*PGS_CW + PGS_C_INBUF];
			pout[p] = fsel[p] ? i_periph_out[p] : outval_reg[p]; // see RL15
			poe[p] = fsel[p] ? i_periph_dir[p] : i_dir[p];
			rsvd[p] = func_all[p*PGS_FW +: PGS_FW] > PGS_FUNC_MAX; // see RL14
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pin_out <= '0;
			o_pin_oe <= '0;
			o_pin_in <= '0;
			o_sampling_on <= '0;
			o_drive_strength <= '0;
			o_pull_resistor_on <= '0;
			o_input_buffer_on <= '0;
			o_function_select_on <= '0;
			o_function_code <= '0;
			o_function_reserved <= '0;
		end else begin
			o_pin_out <= pout;
			o_pin_oe <= poe;
			o_pin_in <= level & inbuf;
			o_sampling_on <= sub_on;
			for (int p = 0; p < PGS_PINS; p++) begin
				o_drive_strength[p] <= cfg_all[p*PGS_CW + PGS_C_DRIVE];
				o_pull_resistor_on[p] <= cfg_all[p*PGS_CW + PGS_C_PULL];
			end
			o_input_buffer_on <= inbuf;
			o_function_select_on <= fsel;
			o_function_code <= func_all;
			o_function_reserved <= rsvd;
		end
	end

	// ==========================================================
	// axi4-lite read channel
	logic [31:0] rdata_next;
	logic rvalid_next;
	always_comb begin
		rdata_next = o_rdata;
		rvalid_next = o_rvalid;
		if (o_rvalid && i_rready) begin
			rvalid_next = 1'b0;
		end
		if (o_arready && i_arvalid) begin
			rvalid_next = 1'b1;
			case (i_araddr)
				PGS_OFS_SAMPLING: rdata_next = sampling_reg;
				PGS_OFS_EVCTL: rdata_next = evctl_reg;
				PGS_OFS_OUTVAL: rdata_next = outval_reg;
				default: rdata_next = '0; // see RL3
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= '0;
			o_rresp <= PGS_AXI_OKAY;
			o_rvalid <= 1'b0;
			o_arready <= 1'b0;
		end else begin
			o_rdata <= rdata_next;
			o_rvalid <= rvalid_next;
			o_arready <= !rvalid_next;
			if (o_arready && i_arvalid) begin
				o_rresp <= (i_araddr == PGS_OFS_SAMPLING || i_araddr == PGS_OFS_EVCTL
					|| i_araddr == PGS_OFS_OUTVAL || i_araddr == PGS_OFS_MULTICFG)
					? PGS_AXI_OKAY : PGS_AXI_SLVERR;
			end
		end
	end

	// ==========================================================
	// checks
	a_sub_group_on: assert property (@(posedge i_clk) disable iff (i_rst) // see RL2
		##1 (o_sampling_on[15:8] == {8{|$past(sampling_reg[15:8])}}))
		else $error("sub-group sampling mismatch");
	a_multicfg_reads_zero: assert property (@(posedge i_clk) disable iff (i_rst) // see RL3
		(o_arready && i_arvalid && i_araddr == PGS_OFS_MULTICFG) |=> (o_rdata == 32'h0))
		else $error("multi-pin config read not zero");
	a_partial_ignored: assert property (@(posedge i_clk) disable iff (i_rst) // see RL4
		(wr_fire && wr_addr == PGS_OFS_MULTICFG && wr_strb != PGS_STRB_FULL)
		|=> $stable(cfg_all) && $stable(func_all))
		else $error("partial multi-pin write took effect");
	a_protect_blocks: assert property (@(posedge i_clk) disable iff (i_rst) // see RL17
		(wr_fire && i_write_protect_unit && i_event == '0)
		|=> $stable(sampling_reg) && $stable(evctl_reg) && $stable(cfg_all))
		else $error("protected write changed state");
	a_cfg_applied: assert property (@(posedge i_clk) disable iff (i_rst) // see RL7
		(mc_cfg_we && wr_data[PGS_B_HALF] && wr_data[0])
		|=> cfg_all[PGS_HALF*PGS_CW +: PGS_CW] == $past({wr_data[PGS_B_DRIVE],
		wr_data[PGS_B_PULL], wr_data[PGS_B_INBUF], wr_data[PGS_B_FSEL]}))
		else $error("pin 16 settings not applied");
	a_func_applied: assert property (@(posedge i_clk) disable iff (i_rst) // see RL9
		(mc_func_we && !wr_data[PGS_B_HALF] && wr_data[PGS_HALF-1])
		|=> func_all[PGS_HALF*PGS_FW-1 -: PGS_FW] == $past(wr_data[PGS_B_FUNC_LO +: PGS_FW]))
		else $error("pin 15 function not applied");
	a_event_set: assert property (@(posedge i_clk) disable iff (i_rst) // see RL12
		(i_event[1] && i_event[3:2] == 2'b00 && evctl_reg[15:13] == 3'b101 && !wr_fire)
		|=> outval_reg[$past(evctl_reg[12:8])])
		else $error("set action missed");
	a_event_off: assert property (@(posedge i_clk) disable iff (i_rst) // see RL11
		((i_event & {evctl_reg[31], evctl_reg[23], evctl_reg[15], evctl_reg[7]}) == 4'h0
		&& !wr_fire) |=> $stable(outval_reg))
		else $error("disabled event changed output");
	a_fsel_mux: assert property (@(posedge i_clk) disable iff (i_rst) // see RL15
		fsel[PGS_HALF] |=> o_pin_out[PGS_HALF] == $past(i_periph_out[PGS_HALF]))
		else $error("peripheral output not routed");
endmodule

// ==== tb/pgs_pin_model.sv ====
// pgs_pin_model: pad levels and event channel pulses seen by the pin group.
// assumes the bench asks for each event during one clock only.
module pgs_pin_model
	import pgs_pkg::*;
(
	input wire logic i_clk,
	input wire logic [PGS_PINS-1:0] i_pattern,
	input wire logic [PGS_NEV-1:0] i_ev_req,
	input wire logic [PGS_NEV-1:0] i_ev_lvl,
	output logic [PGS_PINS-1:0] o_pins,
	output logic [PGS_NEV-1:0] o_event,
	output logic [PGS_NEV-1:0] o_event_level
);
	initial begin
		o_pins = '0;
		o_event = '0;
		o_event_level = '0;
	end

	// level is meaningless between events, so it keeps moving
	always @(posedge i_clk) begin
		o_pins <= i_pattern;
		o_event <= i_ev_req;
		o_event_level <= (|i_ev_req) ? i_ev_lvl : ~o_event_level;
	end
endmodule

// ==== tb/pgs_port_group_tb.sv ====
// pgs_port_group_tb: self-checking bench of the pin group block.
// assumes the register port answers as the axi4-lite slave described for the block.
module pgs_port_group_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pgs_pkg::*;

	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic prot = 1'h0;
	logic [31:0] dir = 32'h0000_00ff, pdir = 32'h0001_0000, pout = 32'h0001_0000;
	logic [31:0] pattern = '0;
	logic [3:0] ev_req = '0, ev_lvl = '0, ev, evl;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, pins, pin_out, pin_oe, pin_in, samp_on, drv, pull, inbuf, fsel, fres;
	logic [127:0] fcode;
	int failures = 0;
	int tests_run = 0;

	pgs_pin_model i_model (.i_clk(clk), .i_pattern(pattern), .i_ev_req(ev_req),
		.i_ev_lvl(ev_lvl), .o_pins(pins), .o_event(ev), .o_event_level(evl));

	pgs_port_group i_dut (.i_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.i_write_protect_unit(prot), .i_pins(pins), .i_dir(dir), .i_event(ev),
		.i_event_level(evl), .i_periph_dir(pdir), .i_periph_out(pout),
		.o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pin_in(pin_in),
		.o_sampling_on(samp_on), .o_drive_strength(drv), .o_pull_resistor_on(pull),
		.o_input_buffer_on(inbuf), .o_function_select_on(fsel),
		.o_function_code(fcode), .o_function_reserved(fres));

	initial begin
		forever #5 clk = ~clk;
	end

	// ==========================================
	// checking and bus tasks
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic hang(input string name);
		failures++;
		$display("BAD %s expected answer seen timeout", name);
		end_sim();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		logic aw, w;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		aw = 1'h1;
		w = 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (aw && awready) begin
				aw = 1'h0;
				awvalid <= 1'h0;
			end
			if (w && wready) begin
				w = 1'h0;
				wvalid <= 1'h0;
			end
			if (bvalid) break;
		end
		if (n == 50) hang("write response");
		bready <= 1'h0;
		chk($sformatf("write resp %h", a), {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		logic ar;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		ar = 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (ar && arready) begin
				ar = 1'h0;
				arvalid <= 1'h0;
			end
			if (rvalid) break;
		end
		if (n == 50) hang("read response");
		rready <= 1'h0;
		chk($sformatf("read data %h", a), ed, rdata);
		chk($sformatf("read resp %h", a), {30'h0, er}, {30'h0, rresp});
	endtask

	task automatic fire(input logic [3:0] m, input logic [3:0] l);
		@(posedge clk);
		ev_req <= m;
		ev_lvl <= l;
		@(posedge clk);
		ev_req <= 4'h0;
		repeat (4) @(posedge clk);
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset();
		rd(PGS_OFS_SAMPLING, 32'h0, PGS_AXI_OKAY);
		rd(PGS_OFS_EVCTL, 32'h0, PGS_AXI_OKAY);
		rd(8'h00, 32'h0, PGS_AXI_SLVERR);
		chk("sampling on", 32'h0, samp_on);
	endtask

	task automatic t_sampling();
		wr(PGS_OFS_SAMPLING, 32'h0001_0100, PGS_STRB_FULL, PGS_AXI_OKAY);
		repeat (2) @(posedge clk);
		chk("sampling on", 32'h00ff_ff00, samp_on);
		rd(PGS_OFS_SAMPLING, 32'h0001_0100, PGS_AXI_OKAY);
	endtask

	task automatic t_multicfg();
		wr(PGS_OFS_MULTICFG, 32'hd943_0005, PGS_STRB_FULL, PGS_AXI_OKAY);
		repeat (2) @(posedge clk);
		chk("drive", 32'h0005_0000, drv);
		chk("pull", 32'h0, pull);
		chk("input buffer", 32'h0005_0000, inbuf);
		chk("function select", 32'h0005_0000, fsel);
		chk("code upper", 32'h0000_0909, fcode[95:64]);
		chk("reserved", 32'h0005_0000, fres);
		wr(PGS_OFS_MULTICFG, 32'h4004_0005, 4'h3, PGS_AXI_OKAY);
		wr(PGS_OFS_MULTICFG, 32'h4004_0005, 4'h1, PGS_AXI_OKAY);
		repeat (2) @(posedge clk);
		chk("pull", 32'h0, pull);
		rd(PGS_OFS_MULTICFG, 32'h0, PGS_AXI_OKAY);
		wr(PGS_OFS_MULTICFG, 32'h1347_8000, PGS_STRB_FULL, PGS_AXI_OKAY);
		repeat (2) @(posedge clk);
		chk("code lower", 32'h3000_0000, fcode[63:32]);
		chk("drive", 32'h0005_0000, drv);
		chk("reserved", 32'h0005_0000, fres);
	endtask

	task automatic t_mux();
		chk("pin oe", 32'h0001_00ff, pin_oe);
		chk("pin out", 32'h0001_0000, pin_out);
		@(posedge clk);
		pdir <= 32'h0004_0000;
		pout <= 32'h0004_0000;
		repeat (3) @(posedge clk);
		chk("pin oe", 32'h0004_00ff, pin_oe);
		chk("pin out", 32'h0004_0000, pin_out);
	endtask

	task automatic t_events();
		wr(PGS_OFS_OUTVAL, 32'h0000_00c0, PGS_STRB_FULL, PGS_AXI_OKAY);
		wr(PGS_OFS_EVCTL, 32'he7c6_a584, PGS_STRB_FULL, PGS_AXI_OKAY);
		rd(PGS_OFS_EVCTL, 32'he7c6_a584, PGS_AXI_OKAY);
		fire(4'h3, 4'h1);
		chk("event set", 32'h0004_00f0, pin_out);
		fire(4'hc, 4'h1);
		chk("event out", 32'h0004_0030, pin_out);
		fire(4'h1, 4'h0);
		chk("event copy", 32'h0004_0020, pin_out);
		wr(PGS_OFS_EVCTL, 32'hff26_a584, PGS_STRB_FULL, PGS_AXI_OKAY);
		fire(4'hc, 4'h0);
		chk("event gate", 32'h8004_0020, pin_out);
		fire(4'h4, 4'h1);
		chk("event gate off", 32'h8004_0020, pin_out);
	endtask

	task automatic t_protect();
		@(posedge clk);
		prot <= 1'h1;
		wr(PGS_OFS_SAMPLING, 32'hffff_ffff, PGS_STRB_FULL, PGS_AXI_OKAY);
		wr(PGS_OFS_MULTICFG, 32'hc047_ffff, PGS_STRB_FULL, PGS_AXI_OKAY);
		wr(PGS_OFS_EVCTL, 32'h0, PGS_STRB_FULL, PGS_AXI_OKAY);
		@(posedge clk);
		prot <= 1'h0;
		rd(PGS_OFS_SAMPLING, 32'h0001_0100, PGS_AXI_OKAY);
		rd(PGS_OFS_EVCTL, 32'hff26_a584, PGS_AXI_OKAY);
		chk("pull", 32'h0, pull);
	endtask

	task automatic t_input();
		@(posedge clk);
		pattern <= 32'h0005_ff00;
		repeat (6) @(posedge clk);
		chk("pin in", 32'h0005_0000, pin_in);
		wr(PGS_OFS_SAMPLING, 32'h0000_0100, PGS_STRB_FULL, PGS_AXI_OKAY);
		repeat (2) @(posedge clk);
		pattern <= 32'h0;
		repeat (6) @(posedge clk);
		chk("pin in held", 32'h0005_0000, pin_in);
	endtask

	// ==========================================
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_sampling();
		t_multicfg();
		t_mux();
		t_events();
		t_protect();
		t_input();
		end_sim();
	end
endmodule
